// ---- pkg/ervd_pkg.sv ----
// Constants, register map and types of the egress rate and VLAN default register bank
// ----------------------------------------------------------------------------
// Summary of operation
// - Rate fields give time per byte, not bandwidth
// - Byte interval is (value plus one) times 20 ns, never under 100 ns
// - Queue01 word: q1 25:13, q0 12:0, 31:26 reserved
// - Queue23 word: q3 25:13, q2 12:0, same layout
// - Ports 1,2 have four rate fields, reset zero
// - Each limit paces only its own port queue
// - Default priority bits 14:12, reset zero, for tagging
// - Default VLAN ID bits 11:0; 31:15 reserved
// - Separate default tag register for ports 0, 1
// - Host port 0 has same two rate registers
// - Tag defaults apply only in hybrid egress type
// ----------------------------------------------------------------------------
package ervd_pkg;

    // ------------------------------------------------------------------------
    // Bus and clock
    // ------------------------------------------------------------------------
    localparam int AXI_ADDR_W = 16;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = AXI_DATA_W / 8;
    localparam int REG_INDEX_W = AXI_ADDR_W - 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
    localparam int RATE_STEP_NS = 20;

    // ------------------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------------------
    localparam int RATE_W = 13;
    localparam int RATE_EVEN_LSB = 0;
    localparam int RATE_ODD_LSB = 13;
    localparam logic [AXI_DATA_W-1:0] RATE_WORD_MASK = 32'h03ffffff;
    localparam int TAG_VID_LSB = 0;
    localparam int TAG_VID_W = 12;
    localparam int TAG_PRIO_LSB = 12;
    localparam int TAG_PRIO_W = 3;
    localparam logic [AXI_DATA_W-1:0] TAG_WORD_MASK = 32'h00007fff;
    localparam int EGR_TYPE_W = 2;
    localparam int EGR_TYPE_P0_LSB = 0;
    localparam int EGR_TYPE_P1_LSB = 8;
    localparam logic [AXI_DATA_W-1:0] EGR_CTRL_MASK = 32'h00000303;
    localparam logic [AXI_DATA_W-1:0] REG_RESET = 32'h00000000;
    localparam int CREDIT_W = 20;

    typedef enum logic [1:0] {
        ERVD_EGR_DUMB = 2'b00,
        ERVD_EGR_ACCESS = 2'b01,
        ERVD_EGR_HYBRID = 2'b10,
        ERVD_EGR_CPU = 2'b11
    } ervd_egress_type_t;

    // ------------------------------------------------------------------------
    // Register map: index, byte address is four times the index
    // ------------------------------------------------------------------------
    localparam int NUM_PORTS = 3;
    localparam int NUM_QUEUES = 4;
    localparam int NUM_CH = NUM_PORTS * NUM_QUEUES;
    localparam int NUM_SLOTS = 9;
    localparam int SLOT_W = 4;
    localparam int SLOT_HOST_TAG = 6;
    localparam int SLOT_P1_TAG = 7;
    localparam int SLOT_EGR_CTRL = 8;
    localparam logic [REG_INDEX_W-1:0] IDX_PORT0_QUEUE01_EGRESS_RATE = 14'h1c0d;
    localparam logic [REG_INDEX_W-1:0] IDX_PORT0_QUEUE23_EGRESS_RATE = 14'h1c0e;
    localparam logic [REG_INDEX_W-1:0] IDX_PORT1_QUEUE01_EGRESS_RATE = 14'h1c0f;
    localparam logic [REG_INDEX_W-1:0] IDX_PORT1_QUEUE23_EGRESS_RATE = 14'h1c10;
    localparam logic [REG_INDEX_W-1:0] IDX_PORT2_QUEUE01_EGRESS_RATE = 14'h1c11;
    localparam logic [REG_INDEX_W-1:0] IDX_PORT2_QUEUE23_EGRESS_RATE = 14'h1c12;
    localparam logic [REG_INDEX_W-1:0] IDX_HOST_PORT_DEFAULT_TAG = 14'h1c13;
    localparam logic [REG_INDEX_W-1:0] IDX_PORT1_DEFAULT_TAG = 14'h1c14;
    localparam logic [REG_INDEX_W-1:0] IDX_EGRESS_TYPE_CTRL = 14'h1c30;

    localparam logic [REG_INDEX_W-1:0] SLOT_INDEX [NUM_SLOTS] = '{
        IDX_PORT0_QUEUE01_EGRESS_RATE, IDX_PORT0_QUEUE23_EGRESS_RATE,
        IDX_PORT1_QUEUE01_EGRESS_RATE, IDX_PORT1_QUEUE23_EGRESS_RATE,
        IDX_PORT2_QUEUE01_EGRESS_RATE, IDX_PORT2_QUEUE23_EGRESS_RATE,
        IDX_HOST_PORT_DEFAULT_TAG, IDX_PORT1_DEFAULT_TAG, IDX_EGRESS_TYPE_CTRL
    };
    localparam logic [AXI_DATA_W-1:0] SLOT_MASK [NUM_SLOTS] = '{
        RATE_WORD_MASK, RATE_WORD_MASK, RATE_WORD_MASK, RATE_WORD_MASK,
        RATE_WORD_MASK, RATE_WORD_MASK, TAG_WORD_MASK, TAG_WORD_MASK, EGR_CTRL_MASK
    };

endpackage

// ---- design/ervd_pacer.sv ----
// Per-queue byte pacer holding egress bytes to the programmed interval
`timescale 1ns/1ps
module ervd_pacer
    import ervd_pkg::*;
#(
    parameter int PACE_RATE_W = RATE_W,
    parameter int PACE_CREDIT_W = CREDIT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PACE_RATE_W-1:0] rate,
    input wire logic byte_valid,
    output logic byte_grant
);

    // ------------------------------------------------------------------------
    // Cost and credit
    // ------------------------------------------------------------------------
    logic [PACE_CREDIT_W-1:0] credit;
    logic [PACE_CREDIT_W-1:0] cost;
    logic [PACE_CREDIT_W-1:0] credit_add;
    logic may_send;

    // Cost of one byte in ns; the rate value is time per byte, not bandwidth
    assign cost = (PACE_CREDIT_W'(rate) + PACE_CREDIT_W'(1))
                * PACE_CREDIT_W'(RATE_STEP_NS);
    assign credit_add = credit + PACE_CREDIT_W'(CLK_PERIOD_NS);
    // One idle cycle after each grant so a held valid is not granted twice
    assign may_send = byte_valid && !byte_grant && (credit >= cost);

    // ------------------------------------------------------------------------
    // Credit: earns one clock period per cycle, capped at one byte of cost
    // ------------------------------------------------------------------------
    // The cap stops an idle queue from banking a burst above its pace
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            credit <= '0;
        end else if (may_send) begin
            credit <= credit_add - cost;
        end else if (credit_add > cost) begin
            credit <= cost;
        end else begin
            credit <= credit_add;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            byte_grant <= 1'b0;
        end else begin
            byte_grant <= may_send;
        end
    end

endmodule // ervd_pacer

// ---- design/ervd_top.sv ----
// Egress rate and default VLAN tag register bank with AXI4-Lite slave and pacers
`timescale 1ns/1ps
module ervd_top
    import ervd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_CH-1:0] egress_byte_valid,
    output logic [NUM_CH-1:0] egress_byte_grant,
    output logic [TAG_VID_W-1:0] port0_tag_vid,
    output logic [TAG_PRIO_W-1:0] port0_tag_prio,
    output logic port0_tag_enable,
    output logic [TAG_VID_W-1:0] port1_tag_vid,
    output logic [TAG_PRIO_W-1:0] port1_tag_prio,
    output logic port1_tag_enable
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [AXI_DATA_W-1:0] strb_mask(input logic [AXI_STRB_W-1:0] strb);
        logic [AXI_DATA_W-1:0] m;
        m = '0;
        for (int b = 0; b < AXI_STRB_W; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

    function automatic logic [SLOT_W:0] decode(input logic [REG_INDEX_W-1:0] idx);
        logic [SLOT_W:0] r;
        r = '0;
        for (int s = 0; s < NUM_SLOTS; s++) begin
            if (idx == SLOT_INDEX[s]) begin
                r = {1'b1, SLOT_W'(s)};
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [AXI_DATA_W-1:0] reg_word [NUM_SLOTS];
    logic aw_held;
    logic w_held;
    logic [REG_INDEX_W-1:0] aw_index;
    logic [AXI_DATA_W-1:0] w_data;
    logic [AXI_STRB_W-1:0] w_strb;
    logic wr_fire;
    logic [SLOT_W:0] wr_dec;
    logic [SLOT_W:0] rd_dec;
    logic [AXI_DATA_W-1:0] rd_value;
    logic [AXI_DATA_W-1:0] wr_merge;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_dec = decode(aw_index);
    assign rd_dec = decode(s_axi_araddr[AXI_ADDR_W-1:2]);

    // ------------------------------------------------------------------------
    // Write address and data channels, taken in either order
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_index <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_index <= s_axi_awaddr[AXI_ADDR_W-1:2];
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------------
    // Unmapped writes are dropped and answered with a decode error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_dec[SLOT_W] ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Register words: byte-strobe merge, reserved bits forced to zero
    // ------------------------------------------------------------------------
    always_comb begin
        wr_merge = '0;
        if (wr_dec[SLOT_W]) begin
            wr_merge = (reg_word[wr_dec[SLOT_W-1:0]] & ~strb_mask(w_strb))
                     | (w_data & strb_mask(w_strb));
        end
    end

    // Rate words for ports 0..2, host and port 1 tag words, egress type word
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                reg_word[s] <= REG_RESET;
            end else if (wr_fire && wr_dec[SLOT_W] && (wr_dec[SLOT_W-1:0] == SLOT_W'(s))) begin
                reg_word[s] <= wr_merge & SLOT_MASK[s];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    always_comb begin
        rd_value = '0;
        if (rd_dec[SLOT_W]) begin
            rd_value = reg_word[rd_dec[SLOT_W-1:0]] & SLOT_MASK[rd_dec[SLOT_W-1:0]];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_dec[SLOT_W] ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Pacers: one per port and queue, each fed only by its own field
    // ------------------------------------------------------------------------
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_pace
        localparam int PORT = ch / NUM_QUEUES;
        localparam int QUEUE = ch % NUM_QUEUES;
        localparam int SLOT = PORT * 2 + QUEUE / 2;
        localparam int LSB = (QUEUE % 2 == 1) ? RATE_ODD_LSB : RATE_EVEN_LSB;
        ervd_pacer #(
            .PACE_RATE_W(RATE_W),
            .PACE_CREDIT_W(CREDIT_W)
        ) u_pacer (
            .aclk(aclk),
            .aresetn(aresetn),
            .rate(reg_word[SLOT][LSB +: RATE_W]),
            .byte_valid(egress_byte_valid[ch]),
            .byte_grant(egress_byte_grant[ch])
        );
    end

    // ------------------------------------------------------------------------
    // Default tag outputs for the tagging datapath
    // ------------------------------------------------------------------------
    // Enables lag a write by one cycle; values follow the words directly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port0_tag_enable <= 1'b0;
            port1_tag_enable <= 1'b0;
        end else begin
            port0_tag_enable <= reg_word[SLOT_EGR_CTRL][EGR_TYPE_P0_LSB +: EGR_TYPE_W]
                              == ERVD_EGR_HYBRID;
            port1_tag_enable <= reg_word[SLOT_EGR_CTRL][EGR_TYPE_P1_LSB +: EGR_TYPE_W]
                              == ERVD_EGR_HYBRID;
        end
    end

    assign port0_tag_vid = reg_word[SLOT_HOST_TAG][TAG_VID_LSB +: TAG_VID_W];
    assign port0_tag_prio = reg_word[SLOT_HOST_TAG][TAG_PRIO_LSB +: TAG_PRIO_W];
    assign port1_tag_vid = reg_word[SLOT_P1_TAG][TAG_VID_LSB +: TAG_VID_W];
    assign port1_tag_prio = reg_word[SLOT_P1_TAG][TAG_PRIO_LSB +: TAG_PRIO_W];

endmodule // ervd_top

// ---- testbench/ervd_props.sv ----
// Port checker for the egress rate and default tag register bank
`timescale 1ns/1ps
module ervd_props
    import ervd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_CH-1:0] egress_byte_valid,
    input wire logic [NUM_CH-1:0] egress_byte_grant,
    input wire logic [TAG_VID_W-1:0] port0_tag_vid,
    input wire logic [TAG_PRIO_W-1:0] port0_tag_prio,
    input wire logic port0_tag_enable,
    input wire logic [TAG_VID_W-1:0] port1_tag_vid,
    input wire logic [TAG_PRIO_W-1:0] port1_tag_prio,
    input wire logic port1_tag_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------------
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_r_answer;
        s_axi_rvalid && (s_axi_rdata[31:26] == 6'h00);
    endsequence
    a_read_answer: assert property (s_ar_taken |=> s_r_answer)
        else $error("read answer late or reserved bits set");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed before taken");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer changed before taken");
    a_write_commit: assert property ($rose(s_axi_bvalid) |->
        $past(s_axi_awready) == 1'b0 && $past(s_axi_wready) == 1'b0)
        else $error("write answer without both address and data held");
    // ------------------------------------------------------------------------
    // Tag outputs and pacing
    // ------------------------------------------------------------------------
    a_tag_update: assert property (
        $changed({port0_tag_prio, port0_tag_vid, port1_tag_prio, port1_tag_vid})
        |-> $rose(s_axi_bvalid))
        else $error("default tag changed without a write");
    a_enable_follow: assert property ($changed({port0_tag_enable, port1_tag_enable})
        |-> $past(s_axi_bvalid))
        else $error("tag enable changed without a write");
    // A forced idle cycle after each grant keeps a held valid from being granted twice
    a_grant_gap: assert property ((egress_byte_grant & $past(egress_byte_grant)) == '0)
        else $error("grant on two cycles in a row");
    a_grant_cause: assert property (
        (egress_byte_grant & ~$past(egress_byte_valid)) == '0)
        else $error("grant on a channel with no byte waiting");
endmodule // ervd_props

bind ervd_top ervd_props chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .egress_byte_valid, .egress_byte_grant, .port0_tag_vid,
    .port0_tag_prio, .port0_tag_enable, .port1_tag_vid, .port1_tag_prio, .port1_tag_enable);

// ---- testbench/ervd_top_tb.sv ----
// Directed bench for the egress rate and default tag register bank
`timescale 1ns/1ps
module ervd_top_tb
    import ervd_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [AXI_DATA_W-1:0] s_axi_wdata = '0;
    logic [AXI_STRB_W-1:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [NUM_CH-1:0] egress_byte_valid = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [AXI_DATA_W-1:0] s_axi_rdata;
    logic [NUM_CH-1:0] egress_byte_grant;
    logic [TAG_VID_W-1:0] port0_tag_vid, port1_tag_vid;
    logic [TAG_PRIO_W-1:0] port0_tag_prio, port1_tag_prio;
    logic port0_tag_enable, port1_tag_enable;
    int n_fail = 0;
    int n_checks = 0;
    logic [1:0] resp;
    logic [31:0] data;
    int cnt [NUM_CH];
    logic [RATE_W-1:0] rt [NUM_CH] = '{13'h0, 13'h3f, 13'h0, 13'h0, 13'h1f, 13'h0, 13'h3f, 13'h0,
        13'h0, 13'h0, 13'h0, 13'h1f};

    ervd_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .egress_byte_valid, .egress_byte_grant, .port0_tag_vid, .port0_tag_prio,
        .port0_tag_enable, .port1_tag_vid, .port1_tag_prio, .port1_tag_enable);

    initial begin
        forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
    end
    // ------------------------------------------------------------------------
    // Report and compare
    // ------------------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic mismatch(input string m);
        n_fail++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic chk_data(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) mismatch($sformatf("%s got %h want %h", m, g, e));
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string m);
        n_checks++;
        if (g !== e) mismatch($sformatf("%s got %h want %h", m, g, e));
    endtask
    task automatic chk_count(input int g, input int lo, input int hi, input string m);
        n_checks++;
        if (g < lo || g > hi) mismatch($sformatf("%s got %0d want %0d..%0d", m, g, lo, hi));
    endtask
    task automatic hang();
        mismatch("wait limit reached");
        final_report();
    endtask
    // ------------------------------------------------------------------------
    // Bus master: valid held until its own ready, answer taken at its edge
    // ------------------------------------------------------------------------
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (k == 40) hang();
    endtask
    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (k == 40) hang();
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial begin
        int iv;
        int e;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            axi_read({SLOT_INDEX[i], 2'b00}, data, resp);
            chk_data(data, REG_RESET, "reset word");
            axi_write({SLOT_INDEX[i], 2'b00}, 32'hffffffff, 4'hf, resp);
            chk_resp(resp, RESP_OKAY, "write answer");
            axi_read({SLOT_INDEX[i], 2'b00}, data, resp);
            chk_data(data, SLOT_MASK[i], "writable bits");
        end
        axi_write({IDX_HOST_PORT_DEFAULT_TAG, 2'b00}, 32'h00005abc, 4'hf, resp);
        axi_write({IDX_PORT1_DEFAULT_TAG, 2'b00}, 32'h00003123, 4'hf, resp);
        repeat (2) @(posedge aclk);
        chk_data({17'h0, port0_tag_prio, port0_tag_vid}, 32'h5abc, "host tag");
        chk_data({17'h0, port1_tag_prio, port1_tag_vid}, 32'h3123, "port1 tag");
        axi_write({IDX_PORT1_DEFAULT_TAG, 2'b00}, 32'hffffffff, 4'h2, resp);
        axi_read({IDX_PORT1_DEFAULT_TAG, 2'b00}, data, resp);
        chk_data(data, 32'h00007f23, "strobed tag byte");
        // Every egress type on both ports, then one port alone
        for (int t = 0; t < 4; t++) begin
            axi_write({IDX_EGRESS_TYPE_CTRL, 2'b00}, (t << 8) | t, 4'hf, resp);
            repeat (3) @(posedge aclk);
            e = (t == 2) ? 3 : 0;
            chk_data({30'h0, port1_tag_enable, port0_tag_enable}, e, "enable");
        end
        axi_write({IDX_EGRESS_TYPE_CTRL, 2'b00}, 32'h00000002, 4'hf, resp);
        repeat (3) @(posedge aclk);
        chk_data({30'h0, port1_tag_enable, port0_tag_enable}, 32'h1, "port0 only");
        axi_write(16'h0100, 32'h12345678, 4'hf, resp);
        chk_resp(resp, RESP_DECERR, "unmapped write");
        axi_read(16'h0100, data, resp);
        chk_resp(resp, RESP_DECERR, "unmapped read");
        chk_data(data, 32'h0, "unmapped data");
        // Slow queues in the odd field of ports 0 and 2 and the even field of port 1 show the field layout
        for (int s = 0; s < 6; s++) begin
            axi_write({SLOT_INDEX[s], 2'b00}, {6'h0, rt[s*2+1], rt[s*2]}, 4'hf, resp);
        end
        foreach (cnt[c]) cnt[c] = 0;
        @(posedge aclk);
        egress_byte_valid <= '1;
        for (int n = 0; n < 640; n++) begin
            @(posedge aclk);
            foreach (cnt[c]) if (egress_byte_grant[c] === 1'b1) cnt[c]++;
        end
        egress_byte_valid <= '0;
        foreach (cnt[c]) begin
            iv = (rt[c] + 1) * RATE_STEP_NS;
            if (iv < 100) iv = 100;
            e = 640 * CLK_PERIOD_NS / iv;
            chk_count(cnt[c], e-3, e+1, "grants");
        end
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read({IDX_PORT1_QUEUE01_EGRESS_RATE, 2'b00}, data, resp);
        chk_data(data, REG_RESET, "rate after reset");
        chk_data({17'h0, port0_tag_prio, port0_tag_vid}, 32'h0, "tag reset");
        chk_data({30'h0, port1_tag_enable, port0_tag_enable}, 32'h0, "enable reset");
        final_report();
    end
endmodule // ervd_top_tb
